// ===== chan_regs.svh
// constants for the channel disconnect and reconnect controller
// assumes inclusion by bare name from the package and the design files
`ifndef CHAN_REGS_SVH
`define CHAN_REGS_SVH
`define CHAN_NUM_SUB       8
`define CHAN_SUB_W         3
`define CHAN_CCW_W         16
`define CHAN_MODE_RESET    1'b0
`define CHAN_MODE_MUX      1'b1
`define CHAN_INSTR_W       3
`define CHAN_INSTR_START   3'h1
`define CHAN_INSTR_TEST    3'h2
`define CHAN_INSTR_TESTCH  3'h3
`define CHAN_INSTR_HALT    3'h4
`define CHAN_INSTR_CLEAR   3'h5
`define CHAN_DEV_W         2
`define CHAN_DEV_BUFFERED  2'h0
`define CHAN_DEV_DISK      2'h1
`define CHAN_DEV_TAPE      2'h2
`define CHAN_DEV_OTHER     2'h3
`define CHAN_SUBM_W        2
`define CHAN_SUBM_NONSHARE 2'h0
`define CHAN_SUBM_MUX      2'h1
`define CHAN_SUBM_DISK     2'h2
`define CHAN_SUBM_SELECTOR 2'h3
`endif

// ===== chan_pkg.sv
// types shared by the channel controller files
// assumes chan_regs.svh is on the include path
`include "chan_regs.svh"
package chan_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RUN    = 4'b0010,
        ST_RELOAD = 4'b0100,
        ST_DISC   = 4'b1000
    } chan_state_e;
    typedef logic [`CHAN_CCW_W-1:0] ccw_t;
endpackage : chan_pkg

// ===== chan_save_mem.sv
// saved subchannel state: resume command word address per subchannel
// assumes one clock, write and read ports on the same clock
`timescale 1ns/1ns
`include "chan_regs.svh"
module chan_save_mem #(
    parameter int DEPTH = `CHAN_NUM_SUB,
    parameter int AW    = `CHAN_SUB_W,
    parameter int DW    = `CHAN_CCW_W
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    initial begin
        if (DEPTH > (1 << AW)) $error("depth exceeds address range");
    end
    logic [DW-1:0] mem [DEPTH];
    // write on demand, read data registered
    always_ff @(posedge clk) begin
        if (wr_en) mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule : chan_save_mem

// ===== chan_disc_ctrl.sv
// channel disconnect, reconnect and availability controller
// assumes control units and instruction logic run on CLK
`timescale 1ns/1ns
`include "chan_regs.svh"
// Operation
// - selector mode keeps channel busy for the whole chained program
// - multiplexing mode disconnects on channel end without device end
// - subchannel saves resume command word at disconnection
// - free channel reloads saved state and resumes at right command word
// - reconnection refused while busy; requester holds its request
// - disconnected channel accepts resumption or a new start
// - channel-available interruption at disconnect if instruction found busy
// - grant only when channel not busy, never preempting
// - serve reconnections in order requests arrived
// - non-sensing disk on multiplexing subchannel disconnects after seek in mux mode
// - non-sensing disk in disk or selector subchannel mode never disconnects
// - tape drives never disconnect in either mode
// - buffered unit record devices on nonshared subchannels disconnect
// - buffered printer reconnect moves next line as one burst
// - mode bit clears to selector at load, chosen at start
// - clear instruction runs as test while mode bit zero
module chan_disc_ctrl #(
    parameter int NSUB = `CHAN_NUM_SUB,
    parameter int SW   = `CHAN_SUB_W
) (
    // clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST_N,
    // mode control
    input  wire logic                      MODE_WR,
    input  wire logic                      MODE_IN,
    input  wire logic                      IPL,
    // instruction request
    input  wire logic                      INSTR_VALID,
    input  wire logic [`CHAN_INSTR_W-1:0]  INSTR_CODE,
    input  wire logic [SW-1:0]             INSTR_SUB,
    input  wire chan_pkg::ccw_t            INSTR_CCW,
    input  wire logic [`CHAN_DEV_W-1:0]    INSTR_DEV,
    input  wire logic [`CHAN_SUBM_W-1:0]   INSTR_SUBM,
    // control unit status
    input  wire logic                      CHAN_END,
    input  wire logic                      DEV_END,
    input  wire logic                      SEEK_DONE,
    input  wire logic                      CCW_ADV,
    input  wire logic                      PROG_DONE,
    input  wire logic [NSUB-1:0]           RECON_REQ,
    // instruction answer
    output logic                           INSTR_ACK,
    output logic                           INSTR_BUSY,
    output logic                           INSTR_AS_TEST,
    // channel state
    output logic                           CHAN_BUSY,
    output logic                           MODE_BIT,
    output logic [SW-1:0]                  ACTIVE_SUB,
    output chan_pkg::ccw_t                 CUR_CCW,
    output logic                           BURST,
    output logic [NSUB-1:0]                RECON_GRANT,
    output logic                           DISC_PULSE,
    output logic                           AVAIL_IRQ,
    output logic                           AVAIL_PEND
);
    // ********************************************
    // elaboration checks
    // ********************************************
    initial begin
        if (NSUB > (1 << SW) || NSUB < 1) $error("subchannel count does not fit index width");
    end

    // ********************************************
    // decode functions
    // ********************************************
    // instruction that qualifies for the availability flag
    function automatic logic qualifies(input logic [`CHAN_INSTR_W-1:0] c);
        return c == `CHAN_INSTR_START || c == `CHAN_INSTR_TEST ||
               c == `CHAN_INSTR_TESTCH || c == `CHAN_INSTR_HALT;
    endfunction : qualifies

    // whether the device/subchannel pair may disconnect in multiplexing mode
    function automatic logic may_disc(input logic [`CHAN_DEV_W-1:0] d, input logic [`CHAN_SUBM_W-1:0] m);
        unique case (d)
            `CHAN_DEV_BUFFERED: return m == `CHAN_SUBM_NONSHARE;
            `CHAN_DEV_DISK:     return m == `CHAN_SUBM_MUX;
            default:            return 1'b0;
        endcase
    endfunction : may_disc

    // ********************************************
    // state
    // ********************************************
    chan_pkg::chan_state_e state_r, state_nxt;
    logic                 mode_r, mode_nxt;
    logic                 pend_r, pend_nxt;
    logic                 mux_r, mux_nxt;
    logic                 disc_ok_r, disc_ok_nxt;
    logic                 buf_r, buf_nxt;
    logic [SW-1:0]        sub_r, sub_nxt;
    chan_pkg::ccw_t       ccw_r, ccw_nxt;
    logic [NSUB-1:0]      grant_r, grant_nxt;
    logic [NSUB-1:0]      req_q_r, req_q_nxt;
    logic [SW-1:0]        fifo_r [NSUB];
    logic [SW-1:0]        fifo_nxt [NSUB];
    logic [SW:0]          cnt_r, cnt_nxt;
    logic                 ack_r, ack_nxt, busy_r, busy_nxt, astest_r, astest_nxt;
    logic                 disc_r, disc_nxt, irq_r, irq_nxt, burst_r, burst_nxt;
    logic [NSUB-1:0]      dmode_r, dmode_nxt;
    logic [NSUB-1:0]      dbuf_r, dbuf_nxt;
    logic                 sv_wr;
    logic [SW-1:0]        sv_addr;
    chan_pkg::ccw_t       sv_rd;

    // saved subchannel state memory
    chan_save_mem #(.DEPTH(NSUB), .AW(SW), .DW(`CHAN_CCW_W)) u_save (
        .clk     (CLK),
        .wr_en   (sv_wr),
        .wr_addr (sub_r),
        .wr_data (ccw_r),
        .rd_addr (sv_addr),
        .rd_data (sv_rd)
    );

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        logic busy;
        logic new_req;
        logic found;
        logic disc_now;
        busy        = state_r != chan_pkg::ST_IDLE && state_r != chan_pkg::ST_DISC;
        new_req     = 1'b0;
        state_nxt   = state_r;
        mode_nxt    = mode_r;
        pend_nxt    = pend_r;
        mux_nxt     = mux_r;
        disc_ok_nxt = disc_ok_r;
        buf_nxt     = buf_r;
        sub_nxt     = sub_r;
        ccw_nxt     = ccw_r;
        grant_nxt   = '0;
        req_q_nxt   = req_q_r;
        fifo_nxt    = fifo_r;
        cnt_nxt     = cnt_r;
        ack_nxt     = 1'b0;
        busy_nxt    = 1'b0;
        astest_nxt  = 1'b0;
        disc_nxt    = 1'b0;
        irq_nxt     = 1'b0;
        burst_nxt   = burst_r;
        dmode_nxt   = dmode_r;
        dbuf_nxt    = dbuf_r;
        sv_wr       = 1'b0;
        sv_addr     = fifo_r[0];
        found       = 1'b0;
        disc_now    = 1'b0;
        // mode bit, cleared at load
        if (IPL) mode_nxt = `CHAN_MODE_RESET;
        else if (MODE_WR) mode_nxt = MODE_IN;
        // queue new reconnection requests in arrival order
        // a request stays marked until the unit drops it, so one still held after its grant is not queued again
        for (int i = 0; i < NSUB; i++) begin
            if (!RECON_REQ[i]) req_q_nxt[i] = 1'b0;
            new_req = RECON_REQ[i] && !req_q_r[i];
            if (new_req && !found && cnt_r < (SW+1)'(NSUB)) begin
                fifo_nxt[cnt_r[SW-1:0]] = SW'(i);
                req_q_nxt[i] = 1'b1;
                found = 1'b1;
            end
        end
        // instruction handling
        if (INSTR_VALID) begin
            ack_nxt = 1'b1;
            if (INSTR_CODE == `CHAN_INSTR_CLEAR && !mode_r) astest_nxt = 1'b1;
            if (busy) begin
                busy_nxt = 1'b1;
                if (qualifies(INSTR_CODE) || (INSTR_CODE == `CHAN_INSTR_CLEAR && !mode_r)) pend_nxt = 1'b1;
            end else if (INSTR_CODE == `CHAN_INSTR_START) begin
                state_nxt   = chan_pkg::ST_RUN;
                sub_nxt     = INSTR_SUB;
                ccw_nxt     = INSTR_CCW;
                mux_nxt     = mode_r;
                disc_ok_nxt = mode_r && may_disc(INSTR_DEV, INSTR_SUBM);
                buf_nxt     = INSTR_DEV == `CHAN_DEV_BUFFERED;
                burst_nxt   = 1'b0;
                dmode_nxt[INSTR_SUB] = mode_r && may_disc(INSTR_DEV, INSTR_SUBM);
                dbuf_nxt[INSTR_SUB]  = INSTR_DEV == `CHAN_DEV_BUFFERED;
            end
        end
        unique case (state_r)
            chan_pkg::ST_IDLE, chan_pkg::ST_DISC: begin
                // grant oldest waiting request only while free
                if (cnt_r != '0 && !(INSTR_VALID && INSTR_CODE == `CHAN_INSTR_START)) begin
                    state_nxt = chan_pkg::ST_RELOAD;
                    sub_nxt   = fifo_r[0];
                    grant_nxt[fifo_r[0]] = 1'b1;
                    for (int k = 0; k < NSUB - 1; k++) fifo_nxt[k] = fifo_nxt[k+1];
                    cnt_nxt = cnt_r - (SW+1)'(1);
                end
            end
            chan_pkg::ST_RELOAD: begin
                ccw_nxt     = sv_rd;
                disc_ok_nxt = dmode_r[sub_r];
                mux_nxt     = 1'b1;
                buf_nxt     = dbuf_r[sub_r];
                burst_nxt   = dbuf_r[sub_r];
                state_nxt   = chan_pkg::ST_RUN;
            end
            chan_pkg::ST_RUN: begin
                if (CCW_ADV) ccw_nxt = ccw_r + chan_pkg::ccw_t'(1);
                if (PROG_DONE) begin
                    state_nxt = chan_pkg::ST_IDLE;
                    burst_nxt = 1'b0;
                    disc_now  = 1'b1;
                end else if (CHAN_END && !DEV_END && mux_r && disc_ok_r) begin
                    state_nxt = chan_pkg::ST_DISC;
                    sv_wr     = 1'b1;
                    burst_nxt = 1'b0;
                    disc_now  = 1'b1;
                end else if (SEEK_DONE && mux_r && disc_ok_r && !buf_r) begin
                    state_nxt = chan_pkg::ST_DISC;
                    sv_wr     = 1'b1;
                    disc_now  = 1'b1;
                end
            end
            default: state_nxt = chan_pkg::ST_IDLE;
        endcase
        // queue push and pop may meet in one cycle; the shift already moved the pushed entry down
        if (found && !(grant_nxt != '0)) cnt_nxt = cnt_r + (SW+1)'(1);
        else if (found && grant_nxt != '0) begin
            cnt_nxt = cnt_r;
        end
        // availability interruption at disconnect
        if (disc_now) begin
            disc_nxt = 1'b1;
            if (pend_r || pend_nxt) begin
                irq_nxt  = 1'b1;
                pend_nxt = 1'b0;
            end
        end
    end

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r   <= chan_pkg::ST_IDLE;
            mode_r    <= `CHAN_MODE_RESET;
            pend_r    <= 1'b0;
            mux_r     <= 1'b0;
            disc_ok_r <= 1'b0;
            buf_r     <= 1'b0;
            sub_r     <= '0;
            ccw_r     <= '0;
            grant_r   <= '0;
            req_q_r   <= '0;
            fifo_r    <= '{default: '0};
            cnt_r     <= '0;
            ack_r     <= 1'b0;
            busy_r    <= 1'b0;
            astest_r  <= 1'b0;
            disc_r    <= 1'b0;
            irq_r     <= 1'b0;
            burst_r   <= 1'b0;
            dmode_r   <= '0;
            dbuf_r    <= '0;
        end else begin
            state_r   <= state_nxt;
            mode_r    <= mode_nxt;
            pend_r    <= pend_nxt;
            mux_r     <= mux_nxt;
            disc_ok_r <= disc_ok_nxt;
            buf_r     <= buf_nxt;
            sub_r     <= sub_nxt;
            ccw_r     <= ccw_nxt;
            grant_r   <= grant_nxt;
            req_q_r   <= req_q_nxt;
            fifo_r    <= fifo_nxt;
            cnt_r     <= cnt_nxt;
            ack_r     <= ack_nxt;
            busy_r    <= busy_nxt;
            astest_r  <= astest_nxt;
            disc_r    <= disc_nxt;
            irq_r     <= irq_nxt;
            burst_r   <= burst_nxt;
            dmode_r   <= dmode_nxt;
            dbuf_r    <= dbuf_nxt;
        end
    end

    // outputs straight from flip-flops, except CHAN_BUSY, an OR of state bits 1 and 2
    assign INSTR_ACK     = ack_r;
    assign INSTR_BUSY    = busy_r;
    assign INSTR_AS_TEST = astest_r;
    assign CHAN_BUSY     = state_r[1] | state_r[2];
    assign MODE_BIT      = mode_r;
    assign ACTIVE_SUB    = sub_r;
    assign CUR_CCW       = ccw_r;
    assign BURST         = burst_r;
    assign RECON_GRANT   = grant_r;
    assign DISC_PULSE    = disc_r;
    assign AVAIL_IRQ     = irq_r;
    assign AVAIL_PEND    = pend_r;
endmodule : chan_disc_ctrl

// ===== chan_disc_ctrl_sva.sv
// assertions on the channel controller ports
// assumes one clock domain, bound onto every chan_disc_ctrl
`timescale 1ns/1ns
`include "chan_regs.svh"
module chan_disc_ctrl_sva #(
    parameter int NSUB = `CHAN_NUM_SUB
) (
    // clock and reset
    input wire logic                     CLK,
    input wire logic                     RST_N,
    // requests
    input wire logic                     IPL,
    input wire logic                     INSTR_VALID,
    input wire logic [`CHAN_INSTR_W-1:0] INSTR_CODE,
    input wire logic [NSUB-1:0]          RECON_REQ,
    // answers
    input wire logic                     INSTR_ACK,
    input wire logic                     INSTR_BUSY,
    input wire logic                     INSTR_AS_TEST,
    input wire logic                     CHAN_BUSY,
    input wire logic                     MODE_BIT,
    input wire logic                     BURST,
    input wire logic [NSUB-1:0]          RECON_GRANT,
    input wire logic                     DISC_PULSE,
    input wire logic                     AVAIL_IRQ,
    input wire logic                     AVAIL_PEND
);
    // ********************
    // port properties
    // ********************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    a_busy_refused: assert property (INSTR_VALID && CHAN_BUSY |=> INSTR_ACK && INSTR_BUSY)
        else $error("busy channel took an instruction");
    a_start_taken: assert property (INSTR_VALID && !CHAN_BUSY && INSTR_CODE == `CHAN_INSTR_START
        |=> INSTR_ACK && !INSTR_BUSY && CHAN_BUSY) else $error("free channel refused a start");
    a_ipl_selector: assert property (IPL |=> !MODE_BIT)
        else $error("mode bit not cleared by load");
    a_clear_as_test: assert property (INSTR_VALID && INSTR_CODE == `CHAN_INSTR_CLEAR
        |=> INSTR_AS_TEST == !$past(MODE_BIT)) else $error("clear not run as test");
    a_irq_at_disc: assert property (AVAIL_IRQ |-> DISC_PULSE && $past(AVAIL_PEND))
        else $error("interruption without disconnect or pending flag");
    a_pend_cleared: assert property (AVAIL_IRQ |-> !AVAIL_PEND)
        else $error("pending flag kept after interruption");
    a_pend_set: assert property (INSTR_VALID && CHAN_BUSY && INSTR_CODE inside {[1:4]}
        |=> AVAIL_PEND || AVAIL_IRQ) else $error("pending flag not set");
    a_grant_free: assert property (RECON_GRANT != '0
        |-> $onehot(RECON_GRANT) && !$past(CHAN_BUSY) && CHAN_BUSY) else $error("grant on busy channel");
    a_grant_to_req: assert property (RECON_GRANT != '0 |-> (RECON_GRANT & ~$past(RECON_REQ)) == '0)
        else $error("grant without request");
    a_disc_frees: assert property (DISC_PULSE |-> !CHAN_BUSY)
        else $error("channel busy after disconnect");
    a_burst_after_grant: assert property ($rose(BURST)
        |-> $past(RECON_GRANT) != '0 || $past(RECON_GRANT, 2) != '0) else $error("burst without grant");
endmodule : chan_disc_ctrl_sva

bind chan_disc_ctrl chan_disc_ctrl_sva #(.NSUB(NSUB)) u_sva (.CLK(CLK), .RST_N(RST_N), .IPL(IPL),
    .INSTR_VALID(INSTR_VALID), .INSTR_CODE(INSTR_CODE), .RECON_REQ(RECON_REQ), .INSTR_ACK(INSTR_ACK),
    .INSTR_BUSY(INSTR_BUSY), .INSTR_AS_TEST(INSTR_AS_TEST), .CHAN_BUSY(CHAN_BUSY), .MODE_BIT(MODE_BIT),
    .BURST(BURST), .RECON_GRANT(RECON_GRANT), .DISC_PULSE(DISC_PULSE), .AVAIL_IRQ(AVAIL_IRQ),
    .AVAIL_PEND(AVAIL_PEND));

// ===== chan_cu_model.sv
// control unit model: asks for the channel back after device end
// assumes device end pulses from the bench and grants from the channel
`timescale 1ns/1ns
module chan_cu_model #(
    parameter int NSUB = 8
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // device end events and channel grants
    input  wire logic [NSUB-1:0] dev_ready,
    input  wire logic [NSUB-1:0] grant,
    // reconnection requests
    output logic      [NSUB-1:0] req
);
    // ********************
    // request handshake
    // ********************
    logic [NSUB-1:0] ready_r;
    logic [NSUB-1:0] seen_r;
    // sample events and grants on the edge the channel uses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_r <= '0;
            seen_r  <= '0;
        end else begin
            ready_r <= dev_ready;
            seen_r  <= grant;
        end
    end
    // each unit keeps its request until its grant was sampled
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req <= (req & ~seen_r) | ready_r;
        end
    end
endmodule : chan_cu_model

// ===== test_chan_disc_ctrl.sv
// self-checking bench for the channel disconnect controller
// assumes design, control unit model and checker compile first
`timescale 1ns/1ns
`include "chan_regs.svh"
module test_chan_disc_ctrl;
    // ********************
    // signals
    // ********************
    logic           CLK, RST_N, MODE_WR, MODE_IN, IPL, INSTR_VALID;
    logic [2:0]     INSTR_CODE, INSTR_SUB, ACTIVE_SUB;
    chan_pkg::ccw_t INSTR_CCW, CUR_CCW, ccw_a, ccw_b;
    logic [1:0]     INSTR_DEV, INSTR_SUBM;
    logic           CHAN_END, DEV_END, SEEK_DONE, CCW_ADV, PROG_DONE;
    logic [7:0]     RECON_REQ, RECON_GRANT, dev_ready;
    logic           INSTR_ACK, INSTR_BUSY, INSTR_AS_TEST, CHAN_BUSY, MODE_BIT;
    logic           BURST, DISC_PULSE, AVAIL_IRQ, AVAIL_PEND;
    logic [12:0]    notes[$];
    int             mismatches = 0, compares = 0, cycles = 0, seed = 34;
    chan_disc_ctrl dut (.CLK(CLK), .RST_N(RST_N), .MODE_WR(MODE_WR), .MODE_IN(MODE_IN), .IPL(IPL),
        .INSTR_VALID(INSTR_VALID), .INSTR_CODE(INSTR_CODE), .INSTR_SUB(INSTR_SUB), .INSTR_CCW(INSTR_CCW),
        .INSTR_DEV(INSTR_DEV), .INSTR_SUBM(INSTR_SUBM), .CHAN_END(CHAN_END), .DEV_END(DEV_END),
        .SEEK_DONE(SEEK_DONE), .CCW_ADV(CCW_ADV), .PROG_DONE(PROG_DONE), .RECON_REQ(RECON_REQ),
        .INSTR_ACK(INSTR_ACK), .INSTR_BUSY(INSTR_BUSY), .INSTR_AS_TEST(INSTR_AS_TEST), .CHAN_BUSY(CHAN_BUSY),
        .MODE_BIT(MODE_BIT), .ACTIVE_SUB(ACTIVE_SUB), .CUR_CCW(CUR_CCW), .BURST(BURST),
        .RECON_GRANT(RECON_GRANT), .DISC_PULSE(DISC_PULSE), .AVAIL_IRQ(AVAIL_IRQ), .AVAIL_PEND(AVAIL_PEND));
    chan_cu_model cu (.clk(CLK), .rst_n(RST_N), .dev_ready(dev_ready), .grant(RECON_GRANT), .req(RECON_REQ));
    // ********************
    // tasks
    // ********************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one instruction; ans is the expected busy and as-test answer
    task automatic instr(input logic [2:0] code, input logic [2:0] sub, input logic [15:0] channel_command_word,
                         input logic [1:0] dev, input logic [1:0] subm, input logic [1:0] ans);
        notes.push_back({1'b1, ans, 10'h000});
        {INSTR_VALID, INSTR_CODE, INSTR_SUB, INSTR_CCW, INSTR_DEV, INSTR_SUBM} = {1'b1, code, sub, channel_command_word, dev, subm};
        @(negedge CLK);
        INSTR_VALID = 1'b0;
        @(negedge CLK);
    endtask : instr
    // one control unit status cycle; dsc is expected disconnect and interruption
    task automatic unit(input logic [4:0] ev, input logic [1:0] dsc, input logic [7:0] gnt);
        if (dsc[1]) notes.push_back({3'h0, dsc, 8'h00});
        if (gnt != 8'h00) notes.push_back({5'h00, gnt});
        {CHAN_END, DEV_END, SEEK_DONE, CCW_ADV, PROG_DONE} = ev;
        @(negedge CLK);
        {CHAN_END, DEV_END, SEEK_DONE, CCW_ADV, PROG_DONE} = 5'h00;
        repeat (5) @(negedge CLK);
    endtask : unit
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // ********************
    // clock, watcher, timeout
    // ********************
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    // each answer, disconnect or grant takes the oldest note
    always @(negedge CLK) begin
        if (RST_N && (INSTR_ACK || DISC_PULSE || RECON_GRANT != 8'h00)) begin
            if (notes.size() == 0) chk(16'hdead, 16'h0000);
            else chk({INSTR_ACK, INSTR_BUSY, INSTR_AS_TEST, DISC_PULSE, AVAIL_IRQ, RECON_GRANT}, notes.pop_front());
        end
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test;
        end
    end
    // ********************
    // main sequence
    // ********************
    initial begin
        {MODE_WR, MODE_IN, IPL, INSTR_VALID, INSTR_CODE, INSTR_SUB, INSTR_CCW, INSTR_DEV, INSTR_SUBM} = '0;
        {CHAN_END, DEV_END, SEEK_DONE, CCW_ADV, PROG_DONE, dev_ready} = '0;
        RST_N = 1'b0;
        repeat (16) @(negedge CLK);
        RST_N = 1'b1;
        @(negedge CLK);
        chk({CHAN_BUSY, MODE_BIT, AVAIL_PEND, BURST}, 16'h0000);
        instr(`CHAN_INSTR_CLEAR, 3'h0, 16'h0000, `CHAN_DEV_OTHER, `CHAN_SUBM_NONSHARE, 2'b01);
        instr(`CHAN_INSTR_START, 3'h3, 16'h0100, `CHAN_DEV_DISK, `CHAN_SUBM_MUX, 2'b00);
        unit(5'h10, 2'b00, 8'h00);
        unit(5'h04, 2'b00, 8'h00);
        unit(5'h02, 2'b00, 8'h00);
        chk({CHAN_BUSY, ACTIVE_SUB}, 16'h000b);
        chk(CUR_CCW, 16'h0101);
        unit(5'h01, 2'b10, 8'h00);
        $display("test selector mode done");
        {MODE_WR, MODE_IN} = 2'b11;
        @(negedge CLK);
        MODE_WR = 1'b0;
        @(negedge CLK);
        chk(MODE_BIT, 16'h0001);
        instr(`CHAN_INSTR_CLEAR, 3'h0, 16'h0000, `CHAN_DEV_OTHER, `CHAN_SUBM_NONSHARE, 2'b00);
        instr(`CHAN_INSTR_START, 3'h4, 16'h0200, `CHAN_DEV_TAPE, `CHAN_SUBM_MUX, 2'b00);
        unit(5'h10, 2'b00, 8'h00);
        unit(5'h01, 2'b10, 8'h00);
        instr(`CHAN_INSTR_START, 3'h6, 16'h0300, `CHAN_DEV_DISK, `CHAN_SUBM_DISK, 2'b00);
        unit(5'h04, 2'b00, 8'h00);
        unit(5'h01, 2'b10, 8'h00);
        $display("test non-disconnecting devices done");
        ccw_a = 16'($random(seed));
        ccw_b = 16'($random(seed));
        instr(`CHAN_INSTR_START, 3'h2, ccw_a, `CHAN_DEV_BUFFERED, `CHAN_SUBM_NONSHARE, 2'b00);
        unit(5'h1a, 2'b00, 8'h00);
        instr(`CHAN_INSTR_TEST, 3'h2, ccw_a, `CHAN_DEV_BUFFERED, `CHAN_SUBM_NONSHARE, 2'b10);
        chk(AVAIL_PEND, 16'h0001);
        unit(5'h10, 2'b11, 8'h00);
        chk({CHAN_BUSY, AVAIL_PEND}, 16'h0000);
        instr(`CHAN_INSTR_START, 3'h5, ccw_b, `CHAN_DEV_DISK, `CHAN_SUBM_MUX, 2'b00);
        unit(5'h04, 2'b10, 8'h00);
        instr(`CHAN_INSTR_START, 3'h1, 16'h0400, `CHAN_DEV_OTHER, `CHAN_SUBM_NONSHARE, 2'b00);
        dev_ready = 8'h20;
        @(negedge CLK);
        dev_ready = 8'h04;
        @(negedge CLK);
        dev_ready = 8'h00;
        for (int c = 1; c <= 4; c++) instr(3'(c), 3'h1, 16'h0000, 2'h3, 2'h0, 2'b10);
        unit(5'h01, 2'b11, 8'h20);
        chk({BURST, CHAN_BUSY, ACTIVE_SUB}, 16'h000d);
        chk(CUR_CCW, ccw_b);
        unit(5'h01, 2'b10, 8'h04);
        chk({BURST, CHAN_BUSY, ACTIVE_SUB}, 16'h001a);
        chk(CUR_CCW, ccw_a + 16'h0001);
        unit(5'h01, 2'b10, 8'h00);
        $display("test reconnection order done");
        IPL = 1'b1;
        @(negedge CLK);
        IPL = 1'b0;
        @(negedge CLK);
        chk({MODE_BIT, 15'(notes.size())}, 16'h0000);
        finish_test;
    end
endmodule : test_chan_disc_ctrl
